// >>> src/ext_bus_pkg.sv
// Package with register map, field layouts, reset values and state codes of the external bus timing block.
package ext_bus_pkg;

  localparam logic [7:0] OFF_ZONE_TIMING = 8'h00;
  localparam logic [7:0] OFF_CLK_MODE = 8'h04;
  localparam logic [7:0] OFF_ADDR = 8'h08;
  localparam logic [7:0] OFF_WDATA = 8'h0C;
  localparam logic [7:0] OFF_CMD = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_RDATA = 8'h18;

  localparam int CMD_RNW_BIT = 0;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_WS_LSB = 8;

  // Zone timing register layout, least significant field last.
  typedef struct packed {
    logic [12:0] rsvd;
    logic ready_sample_mode;
    logic ready_use_enable;
    logic double_timing_option;
    logic [1:0] write_trail_setting;
    logic [3:0] write_active_setting;
    logic [1:0] write_lead_setting;
    logic [1:0] read_trail_setting;
    logic [3:0] read_active_setting;
    logic [1:0] read_lead_setting;
  } zone_timing_s;

  localparam logic [31:0] ZONE_TIMING_RST = 32'h0000_FFFF;
  localparam logic [1:0] CLK_MODE_RST = 2'h0;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [1:0] DIV_RST = 2'h0;

  typedef enum logic [1:0] {
    CLK_MODE_1 = 2'h0,
    CLK_MODE_2 = 2'h1,
    CLK_MODE_3 = 2'h2,
    CLK_MODE_4 = 2'h3
  } clk_mode_e;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ALIGN = 5'h02,
    ST_LEAD = 5'h04,
    ST_ACTIVE = 5'h08,
    ST_TRAIL = 5'h10
  } acc_state_e;

endpackage

// >>> src/sync2.sv
// Two flip-flop synchroniser for levels arriving from outside the core clock domain.
`timescale 1ns/1ns
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end

  assign q = s2_r;

endmodule

// >>> src/clk_ratio_gen.sv
// Timing clock tick and exported bus clock generation for the four clock ratio modes.
`timescale 1ns/1ns
module clk_ratio_gen (
  input wire logic pclk,
  input wire logic presetn,
  input wire ext_bus_pkg::clk_mode_e clk_mode,
  output logic tim_tick,
  output logic bus_rise,
  output logic bus_half,
  output logic exported_bus_clock
);

  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic [1:0] period_m1;
  logic tim_half;
  logic bus_clk_r;

  // Modes 3 and 4 halve the timing clock; modes 2 and 4 halve the exported clock again.
  always_comb begin
    tim_half = (clk_mode == ext_bus_pkg::CLK_MODE_3) || (clk_mode == ext_bus_pkg::CLK_MODE_4);
    bus_half = (clk_mode == ext_bus_pkg::CLK_MODE_2) || (clk_mode == ext_bus_pkg::CLK_MODE_4);
    period_m1 = {tim_half & bus_half, tim_half | bus_half};
    cnt_nxt = (cnt_r >= period_m1) ? 2'h0 : cnt_r + 2'h1;
    tim_tick = tim_half ? !cnt_nxt[0] : 1'b1; // [R11]
    bus_rise = (cnt_nxt == 2'h0);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= ext_bus_pkg::DIV_RST;
      bus_clk_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      bus_clk_r <= (cnt_nxt <= {1'b0, period_m1[1]}); // [R14] [R15]
    end
  end

  // In mode 1 the exported clock is the core clock itself, which no flip-flop can make.
  assign exported_bus_clock = (period_m1 == 2'h0) ? pclk : bus_clk_r; // [R11]

endmodule

// >>> src/ext_bus_access_timing.sv
// External parallel bus access sequencer with lead, active and trail phases and an APB register file.
//
// Operation
// [R1] Lead is lead setting, active is active plus waits plus one, doubled on option.
// [R2] Zones that ignore external ready get no hardware wait states.
// [R3] Accesses not starting on an exported rising edge get alignment cycles first.
// [R4] Alignment cycles keep strobes and select inactive and hold the last address.
// [R5] External ready is sampled asynchronously when enabled with sample mode one; here both sample modes use the synchronised level.
// [R6] Software keeps lead at least one, active two, their sum four.
// [R7] Software does not count ready wait states toward those minimums.
// [R8] Async ready settings are lead1/active2 or lead2/active1, with zero trail.
// [R9] Timing settings are never checked; accesses run exactly as programmed.
// [R10] Lead1/active1 needs double timing; all-zero or lead1/active0 is always illegal.
// [R11] Four clock modes: timing clock full or half core, export full or half.
// [R12] Phase lengths are counted in timing clock cycles.
// [R13] Strobes and select change only on timing clock rising edges.
// [R14] With equal export clock, every strobe change meets an exported rising edge.
// [R15] At half-rate export, even elapsed cycles align rising, odd align falling.
// [R16] Every access starts on an exported rising edge.
// [R17] Strobe assertion aligns by parity of the lead cycle count.
// [R18] Strobe release aligns by parity of lead plus active including waits.
// [R19] Select release aligns by parity of lead, active and trail including waits.
// [R20] External ready passes a two-stage synchroniser before extending active.
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ns
module ext_bus_access_timing #(
  parameter int ADDR_W = 19,
  parameter int DATA_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_ready_in,
  input wire logic [DATA_W-1:0] ext_data_in,
  output logic [DATA_W-1:0] ext_data_out,
  output logic ext_data_oe,
  output logic [ADDR_W-1:0] ext_address_bus,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic zone_select_n,
  output logic read_not_write,
  output logic exported_bus_clock
);

  ////////////////////////////////////////////////////////////////////////////////
  ext_bus_pkg::zone_timing_s zone_timing_register;
  ext_bus_pkg::clk_mode_e clk_mode_r;
  ext_bus_pkg::acc_state_e st_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r, rdata_r, data_s;
  logic req_r, req_rnw_r, rnw_r, use_rdy_r, err_r;
  logic [7:0] lead_cnt_r, act_cnt_r, trail_cnt_r, pc_r, el_r, ws_r;
  logic [31:0] prdata_r;
  logic tim_tick, bus_rise, bus_half, ready_s;
  logic busy_w, wr_w, cmd_w, go_w, lead_end, act_last, ev_wait, ev_act, ev_trail, ev_end;
  logic [7:0] elapsed_w, lead_sel, act_sel, trail_sel;

  function automatic logic [7:0] scale(input logic [3:0] v, input logic dbl);
    scale = dbl ? {3'h0, v, 1'b0} : {4'h0, v};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  clk_ratio_gen u_clk (
    .pclk(pclk), .presetn(presetn), .clk_mode(clk_mode_r), .tim_tick(tim_tick), .bus_rise(bus_rise),
    .bus_half(bus_half), .exported_bus_clock(exported_bus_clock));

  // Both ready sampling modes use the synchronised level, since the pin is asynchronous to pclk.
  sync2 #(.WIDTH(1)) u_rdy_sync (.pclk(pclk), .presetn(presetn), .d(ext_ready_in), .q(ready_s)); // [R5] [R20]

  sync2 #(.WIDTH(DATA_W)) u_data_sync (.pclk(pclk), .presetn(presetn), .d(ext_data_in), .q(data_s));

  ////////////////////////////////////////////////////////////////////////////////
  assign pready = 1'b1;
  assign pslverr = psel & penable & err_r;
  assign prdata = prdata_r;
  assign busy_w = req_r | (st_r != ext_bus_pkg::ST_IDLE);
  assign wr_w = psel & penable & pwrite;
  assign cmd_w = wr_w & (paddr == ext_bus_pkg::OFF_CMD) & !busy_w;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zone_timing_register <= ext_bus_pkg::ZONE_TIMING_RST;
      clk_mode_r <= ext_bus_pkg::CLK_MODE_1;
      addr_r <= '0;
      wdata_r <= '0;
    end else if (wr_w) begin
      if (paddr == ext_bus_pkg::OFF_ZONE_TIMING) begin
        zone_timing_register <= {13'h0000, pwdata[18:0]};
      end else if (paddr == ext_bus_pkg::OFF_CLK_MODE) begin
        clk_mode_r <= ext_bus_pkg::clk_mode_e'(pwdata[1:0]);
      end else if (paddr == ext_bus_pkg::OFF_ADDR) begin
        addr_r <= pwdata[ADDR_W-1:0];
      end else if (paddr == ext_bus_pkg::OFF_WDATA) begin
        wdata_r <= pwdata[DATA_W-1:0];
      end
    end
  end

  // Read data and the error answer are prepared in the setup phase so both come from flip-flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
      err_r <= 1'b0;
    end else if (psel && !penable) begin
      err_r <= 1'b0;
      prdata_r <= '0;
      if (paddr == ext_bus_pkg::OFF_ZONE_TIMING) begin
        prdata_r <= zone_timing_register;
      end else if (paddr == ext_bus_pkg::OFF_CLK_MODE) begin
        prdata_r <= {30'h0000_0000, clk_mode_r};
      end else if (paddr == ext_bus_pkg::OFF_ADDR) begin
        prdata_r[ADDR_W-1:0] <= addr_r;
      end else if (paddr == ext_bus_pkg::OFF_WDATA) begin
        prdata_r[DATA_W-1:0] <= wdata_r;
      end else if (paddr == ext_bus_pkg::OFF_CMD) begin
        prdata_r[ext_bus_pkg::CMD_RNW_BIT] <= req_rnw_r;
      end else if (paddr == ext_bus_pkg::OFF_STATUS) begin
        prdata_r[ext_bus_pkg::STATUS_BUSY_BIT] <= busy_w;
        prdata_r[ext_bus_pkg::STATUS_WS_LSB +: 8] <= ws_r;
      end else if (paddr == ext_bus_pkg::OFF_RDATA) begin
        prdata_r[DATA_W-1:0] <= rdata_r;
      end else begin
        err_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Settings are taken as written; illegal combinations simply run as programmed.
  always_comb begin
    if (pwdata[ext_bus_pkg::CMD_RNW_BIT]) begin
      lead_sel = scale({2'h0, zone_timing_register.read_lead_setting},
                       zone_timing_register.double_timing_option); // [R1] [R9]
      act_sel = scale(zone_timing_register.read_active_setting,
                      zone_timing_register.double_timing_option) + 8'h01;
      trail_sel = scale({2'h0, zone_timing_register.read_trail_setting},
                        zone_timing_register.double_timing_option);
    end else begin
      lead_sel = scale({2'h0, zone_timing_register.write_lead_setting},
                       zone_timing_register.double_timing_option);
      act_sel = scale(zone_timing_register.write_active_setting,
                      zone_timing_register.double_timing_option) + 8'h01;
      trail_sel = scale({2'h0, zone_timing_register.write_trail_setting},
                        zone_timing_register.double_timing_option);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_r <= 1'b0;
      req_rnw_r <= 1'b0;
      use_rdy_r <= 1'b0;
      lead_cnt_r <= ext_bus_pkg::CNT_RST;
      act_cnt_r <= ext_bus_pkg::CNT_RST;
      trail_cnt_r <= ext_bus_pkg::CNT_RST;
    end else if (cmd_w) begin
      req_r <= 1'b1;
      req_rnw_r <= pwdata[ext_bus_pkg::CMD_RNW_BIT];
      lead_cnt_r <= lead_sel;
      act_cnt_r <= act_sel;
      trail_cnt_r <= trail_sel;
      use_rdy_r <= zone_timing_register.ready_use_enable; // [R2]
    end else if (go_w) begin
      req_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // All phase decisions are taken on timing clock ticks only.
  assign go_w = tim_tick & bus_rise & req_r &
                ((st_r == ext_bus_pkg::ST_IDLE) | (st_r == ext_bus_pkg::ST_ALIGN)); // [R16]
  assign lead_end = tim_tick & (st_r == ext_bus_pkg::ST_LEAD) & (pc_r == 8'h01);
  assign act_last = tim_tick & (st_r == ext_bus_pkg::ST_ACTIVE) & (pc_r == 8'h01);
  assign ev_wait = act_last & use_rdy_r & !ready_s; // [R2] [R5]
  assign ev_act = (go_w & (lead_cnt_r == 8'h00)) | lead_end;
  assign ev_trail = act_last & !ev_wait;
  assign ev_end = (ev_trail & (trail_cnt_r == 8'h00)) |
                  (tim_tick & (st_r == ext_bus_pkg::ST_TRAIL) & (pc_r == 8'h01));
  assign elapsed_w = go_w ? 8'h00 : el_r + 8'h01;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ext_bus_pkg::ST_IDLE;
      pc_r <= ext_bus_pkg::CNT_RST;
    end else begin
      case (st_r)
        ext_bus_pkg::ST_IDLE, ext_bus_pkg::ST_ALIGN: begin
          if (go_w) begin
            st_r <= (lead_cnt_r == 8'h00) ? ext_bus_pkg::ST_ACTIVE : ext_bus_pkg::ST_LEAD;
            pc_r <= (lead_cnt_r == 8'h00) ? act_cnt_r : lead_cnt_r;
          end else if (req_r && tim_tick) begin
            st_r <= ext_bus_pkg::ST_ALIGN; // [R3]
          end
        end
        ext_bus_pkg::ST_LEAD: begin
          if (lead_end) begin
            st_r <= ext_bus_pkg::ST_ACTIVE;
            pc_r <= act_cnt_r;
          end else if (tim_tick) begin
            pc_r <= pc_r - 8'h01; // [R12]
          end
        end
        ext_bus_pkg::ST_ACTIVE: begin
          if (ev_trail) begin
            st_r <= (trail_cnt_r == 8'h00) ? ext_bus_pkg::ST_IDLE : ext_bus_pkg::ST_TRAIL;
            pc_r <= trail_cnt_r;
          end else if (tim_tick && !ev_wait) begin
            pc_r <= pc_r - 8'h01;
          end
        end
        ext_bus_pkg::ST_TRAIL: begin
          if (ev_end) begin
            st_r <= ext_bus_pkg::ST_IDLE;
          end else if (tim_tick) begin
            pc_r <= pc_r - 8'h01;
          end
        end
        default: begin
          st_r <= ext_bus_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      el_r <= ext_bus_pkg::CNT_RST;
      ws_r <= ext_bus_pkg::CNT_RST;
    end else if (go_w) begin
      el_r <= ext_bus_pkg::CNT_RST;
      ws_r <= ext_bus_pkg::CNT_RST;
    end else if (tim_tick && busy_w) begin
      el_r <= elapsed_w;
      if (ev_wait && ws_r != 8'hFF) begin
        ws_r <= ws_r + 8'h01; // [R1]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pins move only on tick edges; the address is never cleared, so it holds through idle and alignment.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zone_select_n <= 1'b1;
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      read_not_write <= 1'b1;
      ext_data_oe <= 1'b0;
      ext_address_bus <= '0;
      ext_data_out <= '0;
      rnw_r <= 1'b1;
      rdata_r <= '0;
    end else begin
      if (go_w) begin
        zone_select_n <= 1'b0; // [R13] [R16]
        read_not_write <= req_rnw_r;
        rnw_r <= req_rnw_r;
        ext_address_bus <= addr_r; // [R4]
        ext_data_out <= wdata_r;
        ext_data_oe <= !req_rnw_r;
      end
      if (ev_act) begin
        read_strobe_n <= !(go_w ? req_rnw_r : rnw_r); // [R17]
        write_strobe_n <= go_w ? req_rnw_r : rnw_r;
      end
      if (ev_trail) begin
        read_strobe_n <= 1'b1; // [R18]
        write_strobe_n <= 1'b1;
        if (rnw_r) begin
          rdata_r <= data_s;
        end
      end
      if (ev_end) begin
        zone_select_n <= 1'b1; // [R19]
        read_not_write <= 1'b1;
        ext_data_oe <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_lead_len;
    lead_end |-> elapsed_w == lead_cnt_r;
  endproperty
  a_lead_len: assert property (p_lead_len) else $error("lead phase length wrong"); // [R1] [R12]
  property p_active_len;
    ev_trail |-> elapsed_w == lead_cnt_r + act_cnt_r + ws_r;
  endproperty
  a_active_len: assert property (p_active_len) else $error("active phase length wrong"); // [R1]
  property p_no_ws;
    (st_r == ext_bus_pkg::ST_ACTIVE) && !use_rdy_r |-> ws_r == 8'h00;
  endproperty
  a_no_ws: assert property (p_no_ws) else $error("wait state without ready use"); // [R2]
  property p_align_quiet;
    (st_r == ext_bus_pkg::ST_ALIGN) |-> zone_select_n && read_strobe_n && write_strobe_n && $stable(ext_address_bus);
  endproperty
  a_align_quiet: assert property (p_align_quiet) else $error("activity during alignment"); // [R4]
  property p_start_rise;
    $fell(zone_select_n) |-> $past(tim_tick) && $past(bus_rise);
  endproperty
  a_start_rise: assert property (p_start_rise) else $error("access start not on rising edge"); // [R3] [R16]
  property p_pin_tick;
    $changed(read_strobe_n) || $changed(write_strobe_n) || $changed(zone_select_n) |-> $past(tim_tick);
  endproperty
  a_pin_tick: assert property (p_pin_tick) else $error("strobe moved off a timing edge"); // [R13]
  property p_full_align;
    !bus_half && (ev_act || ev_trail || ev_end) |-> bus_rise;
  endproperty
  a_full_align: assert property (p_full_align) else $error("strobe off rising edge at full rate"); // [R14]
  property p_half_parity;
    bus_half && (ev_act || ev_trail || ev_end) |-> bus_rise == !elapsed_w[0];
  endproperty
  a_half_parity: assert property (p_half_parity) else $error("half rate parity mismatch"); // [R15] [R17] [R18] [R19]
  property p_ready_wait;
    ev_wait |=> (st_r == ext_bus_pkg::ST_ACTIVE) && read_strobe_n == $past(read_strobe_n);
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("not ready did not extend active"); // [R5] [R20]
  c_read_wait: cover property (ev_wait && rnw_r);
  c_align: cover property (st_r == ext_bus_pkg::ST_ALIGN ##1 go_w);
  c_write_half: cover property (ev_end && bus_half && !rnw_r);

endmodule

// >>> sim/ext_mem_model.sv
// Behavioural model of an asynchronous memory with a ready line on the external bus.
`timescale 1ns/1ns
module ext_mem_model (
  input wire logic pclk,
  input wire logic zone_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic read_not_write,
  input wire logic [18:0] ext_address_bus,
  input wire logic [15:0] ext_data_out,
  input wire logic [31:0] stall,
  output logic ext_ready_in,
  output logic [15:0] ext_data_in
);
  logic [15:0] mem [0:15];
  logic [15:0] idle_pat = 16'h5A5A;
  logic rs_q = 1'b1;
  logic ws_q = 1'b1;
  int left = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // The released data bus toggles every cycle so that stale read data cannot pass by luck.
  always @(negedge pclk) begin
    idle_pat <= ~idle_pat;
    rs_q <= read_strobe_n;
    ws_q <= write_strobe_n;
    if (!ws_q && write_strobe_n) begin
      mem[ext_address_bus[3:0]] <= ext_data_out;
    end
    if ((rs_q && !read_strobe_n) || (ws_q && !write_strobe_n)) begin
      left <= stall;
    end else if (left > 0) begin
      left <= left - 1;
    end
  end

  // Ready is pulled up and held low for a set number of cycles after each strobe.
  assign ext_ready_in = (left == 0);
  assign ext_data_in = (!zone_select_n && read_not_write) ? mem[ext_address_bus[3:0]] : idle_pat;
endmodule

// >>> sim/ext_bus_access_timing_tb_top.sv
// Self-checking testbench of the external bus access sequencer.
`timescale 1ns/1ns
module ext_bus_access_timing_tb_top;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, err, acc_done, exp_rnw;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, tw;
  logic ext_ready_in, ext_data_oe, read_strobe_n, write_strobe_n, zone_select_n, read_not_write;
  logic exported_bus_clock;
  logic [15:0] ext_data_in, ext_data_out;
  logic [18:0] ext_address_bus, addr_p;
  logic sel_p = 1'b1, rs_p = 1'b1, ws_p = 1'b1, ex_p = 1'b0;
  int fail_count = 0, compares = 0, cnt = 0, t_sf, t_sr, t_cr, mode_i = 0, stall_cycles;
  // Fields: clock mode, lead, active, trail, double timing, ready use, stall cycles.
  // Read data passes a two-stage synchroniser, so lead plus active spans at least three core cycles.
  int cfg [9][7] = '{'{0, 1, 1, 0, 0, 0, 0}, '{1, 1, 2, 1, 0, 0, 0}, '{1, 2, 1, 0, 0, 0, 0},
    '{2, 1, 1, 2, 1, 0, 0}, '{3, 1, 2, 1, 0, 0, 0}, '{1, 1, 2, 0, 0, 1, 8}, '{0, 1, 1, 0, 1, 1, 0},
    '{0, 0, 2, 0, 0, 0, 8}, '{3, 2, 1, 0, 0, 1, 12}};

  ext_bus_access_timing dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_ready_in(ext_ready_in), .ext_data_in(ext_data_in), .ext_data_out(ext_data_out),
    .ext_data_oe(ext_data_oe), .ext_address_bus(ext_address_bus), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .zone_select_n(zone_select_n), .read_not_write(read_not_write),
    .exported_bus_clock(exported_bus_clock));
  ext_mem_model mem_model (.pclk(pclk), .zone_select_n(zone_select_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .read_not_write(read_not_write), .ext_address_bus(ext_address_bus),
    .ext_data_out(ext_data_out), .stall(stall_cycles), .ext_ready_in(ext_ready_in), .ext_data_in(ext_data_in));

  initial begin
    forever #10 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  task end_sim;
    if (fail_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // One APB transfer; entered just after a rising edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r,
                     output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Runs one bus access and compares phase lengths, counted in core cycles from select low.
  task automatic run_acc(input int i, input logic rnw);
    int m, d, lc, ac, tc, n;
    logic [31:0] st;
    m = cfg[i][4] ? 2 : 1;
    d = (cfg[i][0] >= 2) ? 2 : 1;
    apb(1'b1, ext_bus_pkg::OFF_ADDR, 32'(i + 1), rd, err);
    apb(1'b1, ext_bus_pkg::OFF_WDATA, 32'(16'hA000 + 16'(i) * 16'h0111), rd, err);
    acc_done = 1'b0;
    exp_rnw = rnw;
    apb(1'b1, ext_bus_pkg::OFF_CMD, {31'h0000_0000, rnw}, rd, err);
    n = 0;
    while (!acc_done && n < 400) begin
      @(posedge pclk);
      n++;
    end
    check("access done", 32'h0000_0001, {31'h0000_0000, acc_done});
    apb(1'b0, ext_bus_pkg::OFF_STATUS, 32'h0000_0000, st, err);
    check("busy", 32'h0000_0000, {31'h0000_0000, st[0]});
    if (cfg[i][5] == 0 || cfg[i][6] == 0) check("waits", 32'h0000_0000, {24'h00_0000, st[15:8]});
    else check("waits seen", 32'h0000_0001, {31'h0000_0000, st[15:8] != 8'h00});
    lc = cfg[i][1] * m;
    ac = cfg[i][2] * m + 1 + int'(st[15:8]);
    tc = cfg[i][3] * m;
    check("lead", lc * d, t_sf);
    check("active", (lc + ac) * d, t_sr);
    check("trail", (lc + ac + tc) * d, t_cr);
    if (rnw) begin
      apb(1'b0, ext_bus_pkg::OFF_RDATA, 32'h0000_0000, rd, err);
      check("read data", 32'(16'hA000 + 16'(i) * 16'h0111), rd);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Bus monitor; samples at the falling edge, where every output has settled.
  always @(negedge pclk) begin
    if (presetn) begin
      cnt = (sel_p && !zone_select_n) ? 0 : cnt + 1;
      if (zone_select_n) begin
        check("idle strobes", 32'h0000_0007, {read_strobe_n, write_strobe_n, read_not_write});
        if (sel_p) check("held address", addr_p, ext_address_bus);
      end
      if (sel_p && !zone_select_n) check("start rnw", exp_rnw, read_not_write);
      check("data enable", {31'h0000_0000, !zone_select_n && !read_not_write}, {31'h0000_0000, ext_data_oe});
      if ((rs_p && !read_strobe_n) || (ws_p && !write_strobe_n)) t_sf = cnt;
      if ((!rs_p && read_strobe_n) || (!ws_p && write_strobe_n)) t_sr = cnt;
      if (!sel_p && zone_select_n) begin
        t_cr = cnt;
        acc_done = 1'b1;
      end
      // A mode 1 exported clock is the core clock itself, so only divided modes are checked.
      if (mode_i != 0 && {sel_p, rs_p, ws_p} != {zone_select_n, read_strobe_n, write_strobe_n}) begin
        check("clock edge", {1'b1, mode_i == 2 || (cnt / ((mode_i >= 2) ? 2 : 1)) % 2 == 0},
          {ex_p ^ exported_bus_clock, exported_bus_clock});
      end
    end
    sel_p = zone_select_n;
    rs_p = read_strobe_n;
    ws_p = write_strobe_n;
    ex_p = exported_bus_clock;
    addr_p = ext_address_bus;
  end

  initial begin
    #1_000_000;
    fail_count++;
    end_sim();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    stall_cycles = 0;
    exp_rnw = 1'b1;
    acc_done = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ext_bus_pkg::OFF_ZONE_TIMING, 32'h0000_0000, rd, err);
    check("timing reset", ext_bus_pkg::ZONE_TIMING_RST, rd);
    apb(1'b0, ext_bus_pkg::OFF_CLK_MODE, 32'h0000_0000, rd, err);
    check("mode reset", {30'h0000_0000, ext_bus_pkg::CLK_MODE_RST}, rd);
    apb(1'b1, ext_bus_pkg::OFF_ZONE_TIMING, 32'hFFFF_FFFF, rd, err);
    apb(1'b0, ext_bus_pkg::OFF_ZONE_TIMING, 32'h0000_0000, rd, err);
    check("reserved bits", 32'h0007_FFFF, rd);
    apb(1'b0, 8'h40, 32'h0000_0000, rd, err);
    check("unmapped error", 32'h0000_0001, {31'h0000_0000, err});
    check("unmapped data", 32'h0000_0000, rd);
    for (int i = 0; i < 9; i++) begin
      tw = 32'(cfg[i][1] + cfg[i][2] * 4 + cfg[i][3] * 64);
      tw = tw | (tw << 8) | 32'(cfg[i][4] << 16) | 32'(cfg[i][5] * 3 << 17);
      apb(1'b1, ext_bus_pkg::OFF_CLK_MODE, 32'(cfg[i][0]), rd, err);
      mode_i = cfg[i][0];
      apb(1'b1, ext_bus_pkg::OFF_ZONE_TIMING, tw, rd, err);
      stall_cycles = cfg[i][6];
      run_acc(i, 1'b0);
      run_acc(i, 1'b1);
    end
    end_sim();
  end
endmodule
